/* rtl/float_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module float_unit (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Instruction handover from CPU
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire float_unit_pkg::cmd_s  cmd,
  input  wire logic [63:0]           ext_operand,
  input  wire logic [15:0]           instr_addr,
  // Status toward CPU
  output logic                       busy,
  output logic                       done,
  // Results
  output logic [63:0]                ext_result,
  output logic                       ext_result_valid,
  output float_unit_pkg::flags_s     flags,
  output logic [15:0]                float_exception_address_ptr
);
  import float_unit_pkg::*;

  typedef enum logic [1:0] { ST_IDLE, ST_READ, ST_EXEC, ST_WRITE } state_e;

  state_e       state;
  cmd_s         cur;
  logic [63:0   ] opd_ext;
  logic [15:0]  cur_addr;
  logic [63:0]  acc_a;
  logic [63:0]  acc_b;
  logic [63:0]  res;
  flags_s       res_flags;
  logic         wr_en;
  logic         wr_lo;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // undefined pattern test
  function automatic logic is_undef(input logic [63:0] v);
    return v[SIGN_POS] && (v[62:EXP_LSB] == '0);
  endfunction : is_undef

  // zero exponent reads as exact zero
  function automatic logic [63:0] clean(input logic [63:0] v, input logic dbl);
    logic [63:0] r;
    r = (v[62:EXP_LSB] == '0) ? 64'h0 : v;
    if (!dbl) begin
      r[31:0] = 32'h0;
    end
    return r;
  endfunction : clean

  // mantissa with hidden bit, 56 bits
  function automatic logic [55:0] mant(input logic [63:0] v);
    return (v[62:EXP_LSB] == '0) ? 56'h0 : {1'b1, v[54:0]};
  endfunction : mant

  // pack sign, biased exponent and fraction
  function automatic logic [63:0] pack(input logic s, input logic [9:0] e,
                                       input logic [55:0] m);
    return {s, e[7:0], m[54:0]};
  endfunction : pack

  // ****************************************************************
  // Handover and sequencing
  // ****************************************************************
  // accept then run alone
  assign cmd_ready = (state == ST_IDLE);
  assign busy      = (state != ST_IDLE);
  assign done      = (state == ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:  if (cmd_valid) state <= ST_READ;
        ST_READ:  state <= ST_EXEC;
        ST_EXEC:  state <= ST_WRITE;
        ST_WRITE: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur      <= '0;
      opd_ext  <= '0;
      cur_addr <= '0;
    end else if (cmd_valid && cmd_ready) begin
      cur      <= cmd;
      opd_ext  <= ext_operand;
      cur_addr <= instr_addr;
    end
  end

  float_acc_file #(
    .N (ACC_COUNT),
    .W (ACC_W)
  ) u_acc (
    .clk      (clk),
    .rst_n    (rst_n),
    .rd_a_idx (cur.acc_dst),
    .rd_b_idx (cur.acc_src),
    .rd_a     (acc_a),
    .rd_b     (acc_b),
    .wr_en    (wr_en),
    .wr_idx   (cur.acc_dst),
    .wr_hi    (1'b1),
    .wr_lo    (wr_lo),
    .wr_data  (res)
  );

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic [63:0]        a_v;
  logic [63:0]        b_v;
  logic               ext_bad;
  logic [9:0]         ea;
  logic [9:0]         eb;
  logic [9:0]         er;
  logic [56:0]        sum;
  logic [111:0]       prod;
  logic [55:0]        ma;
  logic [55:0]        mb;
  logic               sr;
  logic signed [31:0] ival;
  logic [31:0]        imag;
  logic [63:0]        next_res;
  flags_s             next_flags;

  assign b_v = (cur.src == SRC_EXT) ? opd_ext : acc_b;
  assign a_v = acc_a;
  assign ext_bad = ((cur.src == SRC_EXT) || (cur.op == OP_STORE))
                   && (cur.acc_dst >= 3'(ACC_XFER));

  always_comb begin
    next_res   = a_v;
    next_flags = '0;
    ea   = {2'b00, a_v[62:EXP_LSB]};
    eb   = {2'b00, b_v[62:EXP_LSB]};
    ma   = mant(clean(a_v, cur.dbl));
    mb   = mant(clean(b_v, cur.dbl));
    er   = ea;
    sr   = a_v[SIGN_POS];
    sum  = '0;
    prod = '0;
    ival = '0;
    imag = '0;
    next_flags.undefined = is_undef(b_v);
    unique case (cur.op)
      OP_LOAD, OP_MOVE: next_res = clean(b_v, cur.dbl);
      OP_STORE:         next_res = a_v;
      OP_ADD, OP_SUB: begin
        // Align on the larger exponent; same-sign path, differing signs subtract
        sr = (cur.op == OP_SUB) ? ~b_v[SIGN_POS] : b_v[SIGN_POS];
        if (ea >= eb) begin
          mb = (ea - eb > 10'd56) ? 56'h0 : mb >> (ea - eb);
        end else begin
          ma = (eb - ea > 10'd56) ? 56'h0 : ma >> (eb - ea);
          er = eb;
        end
        // Differing signs subtract the smaller magnitude from the larger,
        // and the result takes the sign of the larger one; an exact tie
        // yields zero, which is packed as the all-zero word below
        if (sr == a_v[SIGN_POS]) begin
          sum = {1'b0, ma} + {1'b0, mb};
        end else if (ma >= mb) begin
          sum = {1'b0, ma - mb};
          sr  = a_v[SIGN_POS];
        end else begin
          // Operand b is larger, so its effective sign stands
          sum = {1'b0, mb - ma};
        end
        if (sum[56]) begin
          sum = sum >> 1;
          er  = er + 10'd1;
        end
        for (int i = 0; i < 55; i++) begin
          if (!sum[55] && sum != '0) begin
            sum = sum << 1;
            er  = er - 10'd1;
          end
        end
        next_res = (sum == '0) ? 64'h0 : pack(sr, er, sum[55:0]);
      end
      OP_MUL: begin
        prod = ma * mb;
        sr   = a_v[SIGN_POS] ^ b_v[SIGN_POS];
        er   = ea + eb - EXP_BIAS;
        if (!prod[111]) begin
          prod = prod << 1;
          er   = er - 10'd1;
        end
        next_res = (ma == '0 || mb == '0) ? 64'h0 : pack(sr, er, prod[111:56]);
      end
      OP_CONV_IF: begin
        ival = cur.long_int ? b_v[63:32] : {{16{b_v[63]}}, b_v[63:48]};
        sr   = ival[31];
        imag = sr ? 32'(-ival) : 32'(ival);
        er   = EXP_BIAS + 10'd32;
        sum  = {1'b0, imag, 24'h0};
        for (int i = 0; i < 32; i++) begin
          if (!sum[55] && sum != '0) begin
            sum = sum << 1;
            er  = er - 10'd1;
          end
        end
        next_res = (imag == '0) ? 64'h0 : pack(sr, er, sum[55:0]);
      end
      OP_CONV_FI: begin
        er = ea - EXP_BIAS;
        if (ea <= EXP_BIAS) begin
          imag = '0;
        end else if (er > 10'd32) begin
          next_flags.conv_err = 1'b1;
        end else begin
          imag = 32'(ma >> (10'd56 - er));
        end
        if (!cur.long_int && imag > SHORT_MAX) begin
          next_flags.conv_err = 1'b1;
        end
        ival = a_v[SIGN_POS] ? 32'(-imag) : 32'(imag);
        next_res = next_flags.conv_err ? 64'h0 :
                   cur.long_int ? {ival, 32'h0} : {ival[15:0], 48'h0};
        er = ea;
      end
      default: next_res = a_v;
    endcase
    if (cur.op inside {OP_ADD, OP_SUB, OP_MUL} && next_res != '0) begin
      next_flags.overflow  = !er[9] && (er > 10'h0ff);
      next_flags.underflow = er[9] || (er == '0);
      if ((next_flags.overflow && !cur.ovf_int_en) ||
          (next_flags.underflow && !cur.unf_int_en)) begin
        next_res = 64'h0;
      end
    end
    if (!cur.dbl && cur.op != OP_CONV_FI) begin
      next_res[31:0] = '0;
    end
    next_flags.zero     = (next_res[62:0] == '0);
    next_flags.negative = next_res[SIGN_POS];
    next_flags.bad_acc  = ext_bad;
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res       <= '0;
      res_flags <= '0;
    end else if (state == ST_EXEC) begin
      res       <= next_res;
      res_flags <= next_flags;
    end
  end

  assign wr_lo = cur.dbl;
  assign wr_en = (state == ST_WRITE) && !res_flags.bad_acc
                 && !(cur.op inside {OP_STORE, OP_CONV_FI});

  // ext_result and flags hold until the next instruction finishes; ext_result_valid is a one-cycle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_result       <= '0;
      ext_result_valid <= 1'b0;
      flags            <= '0;
    end else begin
      ext_result_valid <= (state == ST_WRITE) && (cur.op inside {OP_STORE, OP_CONV_FI});
      if (state == ST_WRITE) begin
        ext_result <= res;
        flags      <= res_flags;
      end
    end
  end

  // Address of the instruction that raised an exception
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      float_exception_address_ptr <= '0;
    end else if (state == ST_WRITE && (res_flags.overflow || res_flags.underflow
                 || res_flags.conv_err || res_flags.bad_acc)) begin
      float_exception_address_ptr <= cur_addr;
    end
  end
endmodule : float_unit
`default_nettype wire

/* rtl/float_unit_pkg.sv */
package float_unit_pkg;

  // ****************************************************************
  // Formats
  // ****************************************************************
  localparam int          ACC_COUNT     = 6;
  localparam int          ACC_XFER      = 4;
  localparam int          ACC_W         = 64;
  localparam int          SGL_W         = 32;
  localparam int          EXP_W         = 8;
  localparam int          SGL_FRAC_W    = 23;
  localparam int          DBL_FRAC_W    = 55;
  localparam int          SIGN_POS      = 63;
  localparam int          EXP_LSB       = 55;
  localparam logic [9:0]  EXP_BIAS      = 10'h080;
  localparam logic [63:0] ACC_RESET     = 64'h0;
  localparam logic [31:0] SHORT_MAX     = 32'h0000_7fff;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_LOAD, OP_STORE, OP_ADD, OP_SUB, OP_MUL, OP_CONV_IF, OP_CONV_FI, OP_MOVE
  } op_e;

  typedef enum logic [1:0] { SRC_ACC, SRC_EXT } src_e;

  typedef struct packed {
    op_e        op;
    logic [2:0] acc_dst;
    logic [2:0] acc_src;
    src_e       src;
    logic       dbl;
    logic       long_int;
    logic       ovf_int_en;
    logic       unf_int_en;
  } cmd_s;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic undefined;
    logic zero;
    logic negative;
    logic bad_acc;
    logic conv_err;
  } flags_s;

endpackage : float_unit_pkg

/* rtl/float_acc_file.sv */
`timescale 1ns/1ps
`default_nettype none
module float_acc_file #(
  parameter int N = 6,
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Read ports
  input  wire logic [2:0]   rd_a_idx,
  input  wire logic [2:0]   rd_b_idx,
  output logic [W-1:0]      rd_a,
  output logic [W-1:0]      rd_b,
  // Write port with half enables
  input  wire logic         wr_en,
  input  wire logic [2:0]   wr_idx,
  input  wire logic         wr_hi,
  input  wire logic         wr_lo,
  input  wire logic [W-1:0] wr_data
);
  import float_unit_pkg::*;
  logic [W-1:0] mem [N];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // six accumulators
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= ACC_RESET;
      end
    end else if (wr_en && (wr_idx < 3'(N))) begin
      if (wr_hi) begin
        mem[wr_idx][W-1:W/2] <= wr_data[W-1:W/2];
      end
      if (wr_lo) begin
        mem[wr_idx][W/2-1:0] <= wr_data[W/2-1:0];
      end
    end
  end

  // Registered reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_a <= '0;
      rd_b <= '0;
    end else begin
      rd_a <= (rd_a_idx < 3'(N)) ? mem[rd_a_idx] : '0;
      rd_b <= (rd_b_idx < 3'(N)) ? mem[rd_b_idx] : '0;
    end
  end
endmodule : float_acc_file
`default_nettype wire

/* verification/float_unit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module float_unit_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Handover
  input wire logic                   cmd_valid,
  input wire logic                   cmd_ready,
  // Status and results
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic [63:0]            ext_result,
  input wire logic                   ext_result_valid,
  input wire float_unit_pkg::flags_s flags,
  input wire logic [15:0]            float_exception_address_ptr
);
  import float_unit_pkg::*;
  // ****************************************************************
  // Handshake timing
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Three busy cycles, then idle again
  sequence s_busy_run;
    busy [*3] ##1 !busy;
  endsequence
  property p_take;
    cmd_valid && cmd_ready |=> s_busy_run;
  endproperty
  a_take: assert property (p_take)
    else $error("busy window after handover is wrong");
  property p_done;
    done == !busy;
  endproperty
  a_done: assert property (p_done)
    else $error("done does not mirror busy");
  // Handover stays closed for three cycles after a take
  sequence s_closed;
    !cmd_ready [*3] ##1 cmd_ready;
  endsequence
  property p_refuse;
    cmd_valid && cmd_ready |=> s_closed;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("handover offered while busy");
  property p_idle_ready;
    !busy && !cmd_valid |=> !busy;
  endproperty
  a_idle_ready: assert property (p_idle_ready)
    else $error("idle unit left idle without a request");
  property p_valid_one;
    ext_result_valid |=> !ext_result_valid;
  endproperty
  a_valid_one: assert property (p_valid_one)
    else $error("result valid longer than one cycle");
  property p_valid_when;
    ext_result_valid |-> $past(busy) && !busy;
  endproperty
  a_valid_when: assert property (p_valid_when)
    else $error("result valid outside the completion cycle");
  // Results only move when a run completes
  property p_hold;
    !busy |=> $stable(flags) && $stable(ext_result);
  endproperty
  a_hold: assert property (p_hold)
    else $error("results changed while idle");
  property p_ptr;
    $changed(float_exception_address_ptr) |-> $fell(busy);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("exception pointer moved outside completion");
endmodule : float_unit_checker
`default_nettype wire

/* verification/cpu_issuer.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_issuer (
  // Clock
  input  wire logic             clk,
  // Handover toward the unit
  output logic                  cmd_valid,
  input  wire logic             cmd_ready,
  output float_unit_pkg::cmd_s  cmd,
  output logic [63:0]           ext_operand,
  output logic [15:0]           instr_addr
);
  import float_unit_pkg::*;
  // Quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    ext_operand = 64'h0;
    instr_addr = 16'h0;
  end
  // Hand over one instruction and hold it until accepted
  task automatic issue(input cmd_s c, input logic [63:0] opnd, input logic [15:0] adr);
    instr_addr = adr;
    ext_operand = opnd;
    cmd = c;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // Released lines carry no old value, so show its inverse
    ext_operand = ~opnd;
  endtask : issue
endmodule : cpu_issuer
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import float_unit_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid, cmd_ready, busy, done, ext_result_valid;
  cmd_s        cmd;
  flags_s      flags;
  logic [63:0] ext_operand, ext_result, v, want;
  logic [15:0] instr_addr, float_exception_address_ptr;
  logic [63:0] acc_m [6];
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 78064;
  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  always #2 clk = ~clk;
  float_unit dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .ext_operand(ext_operand), .instr_addr(instr_addr), .busy(busy), .done(done),
    .ext_result(ext_result), .ext_result_valid(ext_result_valid), .flags(flags),
    .float_exception_address_ptr(float_exception_address_ptr));
  cpu_issuer cpu (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .ext_operand(ext_operand), .instr_addr(instr_addr));
  // Compare and count
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // Hang guard, generous for about fifty instructions
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      summarize();
    end
  end
  // One instruction through the partner, then checked against the model
  task automatic run(input op_e op, input int a, input logic dbl, input logic [63:0] x);
    cmd_s        c;
    logic [63:0] m;
    logic [15:0] adr;
    int          n;
    c = '0;
    c.op = op;
    c.acc_dst = 3'(a);
    c.acc_src = 3'(a);
    c.src = SRC_EXT;
    c.dbl = dbl;
    adr = 16'h0200 + 16'(a);
    cpu.issue(c, x, adr);
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done", 64'(done), 64'h1);
    if (a >= 4) begin
      check("bad_acc", 64'(flags.bad_acc), 64'h1);
      check("exc_ptr", 64'(float_exception_address_ptr), 64'(adr));
    end else if (op == OP_LOAD) begin
      check("bad_acc", 64'(flags.bad_acc), 64'h0);
      check("valid", 64'(ext_result_valid), 64'h0);
      m = (x[62:55] == 8'h00) ? 64'h0 : x;
      if (dbl) acc_m[a] = m;
      else acc_m[a][63:32] = m[63:32];
    end else if (op inside {OP_ADD, OP_SUB, OP_MUL, OP_CONV_IF}) begin
      check("valid", 64'(ext_result_valid), 64'h0);
      acc_m[a] = want;
    end else begin
      check("valid", 64'(ext_result_valid), 64'h1);
      m = dbl ? 64'hffff_ffff_ffff_ffff : 64'hffff_ffff_0000_0000;
      check("result", ext_result & m, ((op == OP_CONV_FI) ? want : acc_m[a]) & m);
    end
  endtask : run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    foreach (acc_m[i]) acc_m[i] = 64'h0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check("ready", 64'(cmd_ready), 64'h1);
    check("busy", 64'(busy), 64'h0);
    check("flags", 64'(flags), 64'h0);
    // Back-to-back random round trips through the memory-reachable set
    for (int i = 0; i < 12; i++) begin
      v = {$random(seed), $random(seed)};
      v[55] = 1'b1;
      run(OP_LOAD, i % 4, 1'b1, v);
      run(OP_STORE, i % 4, i[0], 64'h0);
    end
    // Single load keeps the lower half
    run(OP_LOAD, 2, 1'b1, 64'h4123_4567_89ab_cdef);
    run(OP_LOAD, 2, 1'b0, 64'hc0fe_dcba_0000_0000);
    run(OP_STORE, 2, 1'b1, 64'h0);
    // Zero exponent and the undefined pattern
    run(OP_LOAD, 1, 1'b1, 64'h0000_0000_1234_5678);
    check("zero", 64'(flags.zero), 64'h1);
    run(OP_STORE, 1, 1'b1, 64'h0);
    run(OP_LOAD, 3, 1'b1, 64'h8000_0000_0000_0001);
    check("undefined", 64'(flags.undefined), 64'h1);
    run(OP_LOAD, 3, 1'b1, 64'h4080_0000_0000_0000);
    // Accumulators 4 and 5 refuse outside transfers
    run(OP_LOAD, 5, 1'b1, 64'h4100_0000_0000_0000);
    run(OP_STORE, 4, 1'b1, 64'h0);
    // Double precision chain on accumulator 0: 1+2, *2, -4, -3
    run(OP_LOAD, 0, 1'b1, 64'h4080_0000_0000_0000);
    want = 64'h4140_0000_0000_0000;
    run(OP_ADD, 0, 1'b1, 64'h4100_0000_0000_0000);
    want = 64'h41c0_0000_0000_0000;
    run(OP_MUL, 0, 1'b1, 64'h4100_0000_0000_0000);
    want = 64'h4100_0000_0000_0000;
    run(OP_SUB, 0, 1'b1, 64'h4180_0000_0000_0000);
    want = 64'hc080_0000_0000_0000;
    run(OP_SUB, 0, 1'b1, 64'h4140_0000_0000_0000);
    check("negative", 64'(flags.negative), 64'h1);
    run(OP_STORE, 0, 1'b1, 64'h0);
    // Overflow and underflow with their interrupts off give exact zero
    run(OP_LOAD, 1, 1'b1, 64'h7f80_0000_0000_0000);
    want = 64'h0;
    run(OP_MUL, 1, 1'b1, 64'h7f80_0000_0000_0000);
    check("overflow", 64'(flags.overflow), 64'h1);
    run(OP_STORE, 1, 1'b1, 64'h0);
    run(OP_LOAD, 2, 1'b1, 64'h0080_0000_0000_0000);
    run(OP_MUL, 2, 1'b1, 64'h0080_0000_0000_0000);
    check("underflow", 64'(flags.underflow), 64'h1);
    run(OP_STORE, 2, 1'b1, 64'h0);
    // Short integer -6 to floating and back
    want = 64'hc1c0_0000_0000_0000;
    run(OP_CONV_IF, 3, 1'b1, 64'hfffa_0000_0000_0000);
    want = 64'hfffa_0000_0000_0000;
    run(OP_CONV_FI, 3, 1'b1, 64'h0);
    // Reset in mid-run returns to idle with cleared accumulators
    cpu.issue('{op: OP_LOAD, acc_dst: 3'h0, src: SRC_EXT, dbl: 1'b1, default: '0},
      64'h4200_0000_0000_0000, 16'h0300);
    rst_n = 1'b0;
    foreach (acc_m[i]) acc_m[i] = 64'h0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("busy", 64'(busy), 64'h0);
    check("done", 64'(done), 64'h1);
    run(OP_STORE, 0, 1'b1, 64'h0);
    summarize();
  end
endmodule : testbench
bind float_unit float_unit_checker chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .busy(busy), .done(done), .ext_result(ext_result),
  .ext_result_valid(ext_result_valid), .flags(flags),
  .float_exception_address_ptr(float_exception_address_ptr));
`default_nettype wire
